//--- rtl/esf_pkg.sv
/*
 * Constants for the exception stack frame builder: frame formats, byte
 * offsets, frame lengths and exception cause codes.
 * Assumes a byte-addressed supervisor stack on a 32-bit data bus.
 */
package esf_pkg;

	// ==========================================================
	// Frame format codes
	localparam logic [3:0] ESF_FMT_NORMAL = 4'h0;
	localparam logic [3:0] ESF_FMT_THROW  = 4'h1;
	localparam logic [3:0] ESF_FMT_SIX    = 4'h2;
	localparam logic [3:0] ESF_FMT_MID    = 4'h9;

	// ==========================================================
	// Byte offsets inside a frame
	localparam logic [7:0] ESF_OFF_SR    = 8'h00;
	localparam logic [7:0] ESF_OFF_PC    = 8'h02;
	localparam logic [7:0] ESF_OFF_FMT   = 8'h06;
	localparam logic [7:0] ESF_OFF_IADDR = 8'h08;
	localparam logic [7:0] ESF_OFF_INTR  = 8'h0c;

	// ==========================================================
	// Frame lengths in 16-bit words and in bytes
	localparam logic [3:0] ESF_WORDS_FOUR = 4'h4;
	localparam logic [3:0] ESF_WORDS_SIX  = 4'h6;
	localparam logic [3:0] ESF_WORDS_TEN  = 4'ha;
	localparam logic [7:0] ESF_BYTES_FOUR = 8'h08;
	localparam logic [7:0] ESF_BYTES_SIX  = 8'h0c;
	localparam logic [7:0] ESF_BYTES_TEN  = 8'h14;

	// Frame image depth in 16-bit words
	localparam int ESF_IMG_DEPTH = 10;
	localparam int ESF_IMG_AW    = 4;

	// ==========================================================
	// Exception cause codes
	typedef enum logic [4:0] {
		ESF_EXC_INTERRUPT      = 5'h00,
		ESF_EXC_FORMAT_ERR     = 5'h01,
		ESF_EXC_TRAP_N         = 5'h02,
		ESF_EXC_ILLEGAL        = 5'h03,
		ESF_EXC_ALINE          = 5'h04,
		ESF_EXC_FLINE          = 5'h05,
		ESF_EXC_PRIV           = 5'h06,
		ESF_EXC_CP_PRE         = 5'h07,
		ESF_EXC_BOUNDS         = 5'h08,
		ESF_EXC_DUAL_BOUNDS    = 5'h09,
		ESF_EXC_CP_COND_TRAP   = 5'h0a,
		ESF_EXC_COND_TRAP      = 5'h0b,
		ESF_EXC_OVERFLOW_TRAP  = 5'h0c,
		ESF_EXC_TRACE          = 5'h0d,
		ESF_EXC_ZERO_DIV       = 5'h0e,
		ESF_EXC_MMU_CFG        = 5'h0f,
		ESF_EXC_CP_POST        = 5'h10,
		ESF_EXC_CP_MID         = 5'h11,
		ESF_EXC_PROTO_VIOL     = 5'h12,
		ESF_EXC_INT_IN_CP      = 5'h13
	} esf_exc_t;

	// Builder states, one-hot
	typedef enum logic [4:0] {
		ESF_ST_IDLE  = 5'b00001,
		ESF_ST_FILL  = 5'b00010,
		ESF_ST_WRITE = 5'b00100,
		ESF_ST_READ  = 5'b01000,
		ESF_ST_DONE  = 5'b10000
	} esf_state_t;

endpackage : esf_pkg

//--- rtl/esf_frame_mem.sv
/*
 * Frame image store: ten 16-bit words, registered dual-word read.
 * Assumes one write port and a read address that may change every cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module esf_frame_mem
	import esf_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  we_i,
	input  wire logic [ESF_IMG_AW-1:0] waddr_i,
	input  wire logic [15:0]           wdata_i,
	input  wire logic [ESF_IMG_AW-1:0] raddr_i,
	output logic      [31:0]           rdata_o
);

	logic [15:0] mem [ESF_IMG_DEPTH];
	logic [ESF_IMG_AW-1:0] raddr_hi;

	assign raddr_hi = raddr_i + 4'h1;

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Big-endian pair: lower address in the upper half
	always_ff @(posedge clk_i) begin
		rdata_o <= {mem[raddr_i], mem[raddr_hi]};
	end

endmodule : esf_frame_mem

`default_nettype wire

//--- rtl/esf_builder.sv
/*
 * Exception stack frame builder: picks the frame format for an exception,
 * lays the frame out, pushes it on the supervisor stack with 32-bit writes
 * and can read back the SR, PC and format/vector word of a frame for return from exception.
 * Assumes a word-aligned 32-bit stack memory port answering with ack.
 */
`timescale 1ns/10ps
`default_nettype none

// How it works
// (RULE1) Frame moved as 32-bit long words
// (RULE2) Frame words written last-to-first, not sequential
// (RULE3) Format 0: SR, PC, format/vector word
// (RULE4) Plain exceptions produce the format 0
// (RULE5) Master-to-interrupt transition adds throwaway frame
// (RULE6) Format 2 adds instruction address at 8
// (RULE7) Post-instruction traps give six-word frame
// (RULE8) Midinstruction frame: ten words, format 1001
// (RULE9) Coprocessor mid conditions give ten-word frame
// (RULE10) Push, lower stack pointer, then fetch vector
module esf_builder
	import esf_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        exc_req_i,
	input  wire logic [4:0]  exc_cause_i,
	input  wire logic [11:0] vec_off_i,
	input  wire logic [15:0] sr_i,
	input  wire logic [31:0] pc_i,
	input  wire logic [31:0] iaddr_i,
	input  wire logic [63:0] intregs_i,
	input  wire logic [31:0] sp_i,
	input  wire logic        throwaway_i,
	input  wire logic        rd_req_i,
	output logic             busy_o,
	output logic             done_o,
	output logic [31:0]      sp_o,
	output logic [3:0]       fmt_o,
	output logic [15:0]      rd_sr_o,
	output logic [31:0]      rd_pc_o,
	output logic [15:0]      rd_fmtvec_o,
	output logic             vec_fetch_o,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic [31:0]      mem_addr_o,
	output logic [31:0]      mem_wdata_o,
	input  wire logic        mem_ack_i,
	input  wire logic [31:0] mem_rdata_i
);

	// ==========================================================
	// Format selection
	esf_state_t  state_reg;
	logic [3:0]  fmt_sel;
	logic [3:0]  words_sel;
	logic [7:0]  bytes_sel;

	always_comb begin
		case (esf_exc_t'(exc_cause_i))
			ESF_EXC_BOUNDS, ESF_EXC_DUAL_BOUNDS, ESF_EXC_CP_COND_TRAP,
			ESF_EXC_COND_TRAP, ESF_EXC_OVERFLOW_TRAP, ESF_EXC_TRACE,
			ESF_EXC_ZERO_DIV, ESF_EXC_MMU_CFG, ESF_EXC_CP_POST: begin
				fmt_sel   = ESF_FMT_SIX; // RULE7
				words_sel = ESF_WORDS_SIX;
				bytes_sel = ESF_BYTES_SIX;
			end
			ESF_EXC_CP_MID, ESF_EXC_PROTO_VIOL, ESF_EXC_INT_IN_CP: begin
				fmt_sel   = ESF_FMT_MID; // RULE9
				words_sel = ESF_WORDS_TEN;
				bytes_sel = ESF_BYTES_TEN;
			end
			default: begin
				fmt_sel   = ESF_FMT_NORMAL; // RULE4
				words_sel = ESF_WORDS_FOUR;
				bytes_sel = ESF_BYTES_FOUR;
			end
		endcase
	end

	// ==========================================================
	// Frame image fill
	logic [3:0]  fill_idx_reg;
	logic [3:0]  nwords_reg;
	logic [7:0]  nbytes_reg;
	logic [15:0] fill_word;
	logic [31:0] pc_reg;
	logic [31:0] iaddr_reg;
	logic [63:0] intregs_reg;
	logic [15:0] sr_reg;
	logic [11:0] vec_reg;
	logic        throw_pend_reg;
	logic [3:0]  rd_idx;
	logic [31:0] img_rdata;
	logic        img_we;

	always_comb begin
		case (fill_idx_reg)
			4'h0: fill_word = sr_reg; // RULE3
			4'h1: fill_word = pc_reg[31:16];
			4'h2: fill_word = pc_reg[15:0];
			4'h3: fill_word = {fmt_o, vec_reg}; // RULE3
			4'h4: fill_word = iaddr_reg[31:16]; // RULE6
			4'h5: fill_word = iaddr_reg[15:0];
			4'h6: fill_word = intregs_reg[63:48]; // RULE8
			4'h7: fill_word = intregs_reg[47:32];
			4'h8: fill_word = intregs_reg[31:16];
			default: fill_word = intregs_reg[15:0];
		endcase
	end

	assign img_we = (state_reg == ESF_ST_FILL);

	esf_frame_mem u_img (
		.clk_i   (clk_i),
		.we_i    (img_we),
		.waddr_i (fill_idx_reg),
		.wdata_i (fill_word),
		.raddr_i (rd_idx),
		.rdata_o (img_rdata)
	);

	// ==========================================================
	// Stack transfer control
	logic [3:0]  xfer_idx_reg;
	logic        pend_reg;
	logic [31:0] base_reg;

	// Highest pair first; read data for the pair is one cycle late
	assign rd_idx = xfer_idx_reg;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg      <= ESF_ST_IDLE;
			fill_idx_reg   <= 4'h0;
			xfer_idx_reg   <= 4'h0;
			pend_reg       <= 1'b0;
			nwords_reg     <= 4'h0;
			nbytes_reg     <= 8'h00;
			fmt_o          <= 4'h0;
			sp_o           <= 32'h0;
			base_reg       <= 32'h0;
			throw_pend_reg <= 1'b0;
			sr_reg         <= 16'h0;
			vec_reg        <= 12'h0;
			pc_reg         <= 32'h0;
			iaddr_reg      <= 32'h0;
			intregs_reg    <= 64'h0;
		end else begin
			case (state_reg)
				ESF_ST_IDLE: begin
					if (exc_req_i) begin
						fmt_o          <= fmt_sel;
						nwords_reg     <= words_sel;
						nbytes_reg     <= bytes_sel;
						throw_pend_reg <= throwaway_i;
						sr_reg         <= sr_i;
						vec_reg        <= vec_off_i;
						pc_reg         <= pc_i;
						iaddr_reg      <= iaddr_i;
						intregs_reg    <= intregs_i;
						base_reg       <= sp_i - 32'(bytes_sel); // RULE10
						fill_idx_reg   <= 4'h0;
						state_reg      <= ESF_ST_FILL;
					end else if (rd_req_i) begin
						base_reg     <= sp_i;
						xfer_idx_reg <= 4'h0;
						pend_reg     <= 1'b0;
						state_reg    <= ESF_ST_READ;
					end
				end
				ESF_ST_FILL: begin
					if (fill_idx_reg == nwords_reg - 4'h1) begin
						xfer_idx_reg <= nwords_reg - 4'h2; // RULE2
						pend_reg     <= 1'b0;
						state_reg    <= ESF_ST_WRITE;
					end else begin
						fill_idx_reg <= fill_idx_reg + 4'h1;
					end
				end
				ESF_ST_WRITE: begin
					if (!pend_reg) begin
						pend_reg <= 1'b1;
					end else if (mem_ack_i) begin
						pend_reg <= 1'b0;
						if (xfer_idx_reg == 4'h0) begin
							if (throw_pend_reg) begin
								// Same SR and PC, format 1, eight bytes below the first frame on the same stack
								throw_pend_reg <= 1'b0;
								fmt_o          <= ESF_FMT_THROW; // RULE5
								nwords_reg     <= ESF_WORDS_FOUR;
								nbytes_reg     <= ESF_BYTES_FOUR;
								base_reg       <= base_reg - 32'(ESF_BYTES_FOUR);
								fill_idx_reg   <= 4'h3;
								sp_o           <= base_reg;
								state_reg      <= ESF_ST_FILL;
							end else begin
								sp_o      <= base_reg; // RULE10
								state_reg <= ESF_ST_DONE;
							end
						end else begin
							xfer_idx_reg <= xfer_idx_reg - 4'h2;
						end
					end
				end
				ESF_ST_READ: begin
					if (!pend_reg) begin
						pend_reg <= 1'b1;
					end else if (mem_ack_i) begin
						pend_reg <= 1'b0;
						if (xfer_idx_reg == 4'h2) begin
							state_reg <= ESF_ST_DONE;
						end else begin
							xfer_idx_reg <= xfer_idx_reg + 4'h2;
						end
					end
				end
				ESF_ST_DONE: begin
					state_reg <= ESF_ST_IDLE;
				end
				default: begin
					state_reg <= ESF_ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Read-back capture; long word at even word offsets
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_sr_o     <= 16'h0;
			rd_pc_o     <= 32'h0;
			rd_fmtvec_o <= 16'h0;
		end else if (state_reg == ESF_ST_READ && pend_reg && mem_ack_i) begin
			if (xfer_idx_reg == 4'h0) begin
				rd_sr_o         <= mem_rdata_i[31:16]; // RULE1
				rd_pc_o[31:16]  <= mem_rdata_i[15:0];
			end else begin
				rd_pc_o[15:0]   <= mem_rdata_i[31:16];
				rd_fmtvec_o     <= mem_rdata_i[15:0];
			end
		end
	end

	assign busy_o      = (state_reg != ESF_ST_IDLE);
	assign done_o      = (state_reg == ESF_ST_DONE);
	assign vec_fetch_o = done_o && !mem_we_o; // RULE10
	assign mem_req_o   = (state_reg == ESF_ST_WRITE || state_reg == ESF_ST_READ) && pend_reg;
	assign mem_we_o    = (state_reg == ESF_ST_WRITE);
	assign mem_addr_o  = base_reg + {27'h0, xfer_idx_reg, 1'b0}; // RULE1
	assign mem_wdata_o = img_rdata; // RULE1

	// ==========================================================
	// Checks
	a_push_sp_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ESF_ST_IDLE && exc_req_i)
		|=> (base_reg == $past(sp_i) - 32'($past(bytes_sel))))
		else $error("frame base not below stack pointer"); // RULE10
	a_six_format: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ESF_ST_IDLE && exc_req_i &&
		 esf_exc_t'(exc_cause_i) == ESF_EXC_ZERO_DIV) |=> (fmt_o == ESF_FMT_SIX))
		else $error("zero divide not six-word"); // RULE7
	a_mid_format: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ESF_ST_IDLE && exc_req_i &&
		 esf_exc_t'(exc_cause_i) == ESF_EXC_CP_MID) |=> (nwords_reg == ESF_WORDS_TEN))
		else $error("midinstruction frame not ten words"); // RULE8 RULE9
	a_norm_format: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ESF_ST_IDLE && exc_req_i &&
		 esf_exc_t'(exc_cause_i) == ESF_EXC_TRAP_N) |=> (fmt_o == ESF_FMT_NORMAL))
		else $error("trap not format zero"); // RULE4
	a_fmt_word_top: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(img_we && fill_idx_reg == 4'h3 && fmt_o != ESF_FMT_THROW &&
		 nwords_reg == ESF_WORDS_FOUR) |-> (fill_word[15:12] == 4'h0))
		else $error("format word top bits wrong"); // RULE3
	a_sp_lowered: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ESF_ST_WRITE && pend_reg && mem_ack_i &&
		 xfer_idx_reg == 4'h0 && !throw_pend_reg)
		|=> (done_o && sp_o == $past(base_reg)))
		else $error("stack pointer not lowered at push end"); // RULE10
	a_done_sp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(state_reg == ESF_ST_DONE) && $past(state_reg) == ESF_ST_WRITE
		|-> (sp_o == mem_addr_o - {27'h0, xfer_idx_reg, 1'b0}))
		else $error("stack pointer not at frame base"); // RULE10
	a_write_aligned: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(mem_req_o) |-> (mem_addr_o[0] == 1'b0))
		else $error("odd stack address"); // RULE1
	a_throw_fmt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ESF_ST_WRITE && mem_ack_i && pend_reg &&
		 xfer_idx_reg == 4'h0 && throw_pend_reg) |=> (fmt_o == ESF_FMT_THROW))
		else $error("throwaway frame not format one"); // RULE5
	a_iaddr_slot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(img_we && fill_idx_reg == 4'h4) |-> (fill_word == iaddr_reg[31:16]))
		else $error("instruction address misplaced"); // RULE6
	a_desc_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ESF_ST_WRITE && pend_reg && mem_ack_i && xfer_idx_reg != 4'h0)
		|=> (xfer_idx_reg == $past(xfer_idx_reg) - 4'h2))
		else $error("write order broken"); // RULE2

	c_norm_push: cover property (@(posedge clk_i) state_reg == ESF_ST_DONE && fmt_o == ESF_FMT_NORMAL);
	c_throw_push: cover property (@(posedge clk_i) state_reg == ESF_ST_DONE && fmt_o == ESF_FMT_THROW);
	c_mid_push: cover property (@(posedge clk_i) state_reg == ESF_ST_DONE && fmt_o == ESF_FMT_MID);
	c_readback: cover property (@(posedge clk_i) $past(state_reg) == ESF_ST_READ && done_o);

endmodule : esf_builder

`default_nettype wire

//--- tb/esf_stack_mem.sv
/*
 * Supervisor stack memory model for the frame builder bench.
 * Assumes a level request held until a one-cycle ack on clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module esf_stack_mem (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  dly_i,
	output logic             ack_o,
	output logic      [31:0] rdata_o
);
	logic [31:0] store [4096];
	logic [3:0]  wait_reg;
	int          wr_cnt = 0;
	int          bad_align = 0;

	// ==========================================================
	// Ack after dly_i cycles; read bus toggles when not answering
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_o    <= 1'b0;
			wait_reg <= 4'h0;
			rdata_o  <= 32'h5a5a_a5a5;
		end else begin
			ack_o   <= 1'b0;
			rdata_o <= ~rdata_o;
			if (req_i && !ack_o) begin
				if (wait_reg < dly_i) begin
					wait_reg <= wait_reg + 4'h1;
				end else begin
					ack_o    <= 1'b1;
					wait_reg <= 4'h0;
					if (addr_i[1:0] != 2'h0) bad_align <= bad_align + 1;
					if (we_i) begin
						store[addr_i[13:2]] <= wdata_i;
						wr_cnt              <= wr_cnt + 1;
					end else begin
						rdata_o <= store[addr_i[13:2]];
					end
				end
			end
		end
	end
endmodule : esf_stack_mem

`default_nettype wire

//--- tb/exception_stack_frame_builder_bench.sv
/*
 * Self-checking bench for the exception stack frame builder.
 * Assumes esf_stack_mem as the stack memory behind the builder.
 */
`timescale 1ns/10ps
`default_nettype none

module exception_stack_frame_builder_bench
	import esf_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        exc_req_i = 1'b0;
	logic [4:0]  exc_cause_i = 5'h00;
	logic [11:0] vec_off_i = 12'h000;
	logic [15:0] sr_i = 16'h0000;
	logic [31:0] pc_i = 32'h0, iaddr_i = 32'h0, sp_i = 32'h0;
	logic [63:0] intregs_i = 64'h0;
	logic        throwaway_i = 1'b0;
	logic        rd_req_i = 1'b0;
	logic        busy_o, done_o, vec_fetch_o, mem_req_o, mem_we_o, mem_ack_i;
	logic [31:0] sp_o, rd_pc_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic [3:0]  fmt_o;
	logic [15:0] rd_sr_o, rd_fmtvec_o;
	logic [3:0]  dly = 4'h0;
	int          bad_count = 0;
	int          n_checks = 0;

	always #10 clk_i = ~clk_i;

	esf_builder dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .exc_req_i(exc_req_i),
		.exc_cause_i(exc_cause_i), .vec_off_i(vec_off_i), .sr_i(sr_i), .pc_i(pc_i),
		.iaddr_i(iaddr_i), .intregs_i(intregs_i), .sp_i(sp_i), .throwaway_i(throwaway_i),
		.rd_req_i(rd_req_i), .busy_o(busy_o), .done_o(done_o), .sp_o(sp_o), .fmt_o(fmt_o),
		.rd_sr_o(rd_sr_o), .rd_pc_o(rd_pc_o), .rd_fmtvec_o(rd_fmtvec_o),
		.vec_fetch_o(vec_fetch_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i));

	esf_stack_mem mem (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(mem_req_o),
		.we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .dly_i(dly),
		.ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_done();
		int n;
		n = 0;
		while (done_o !== 1'b1 && n < 300) begin
			@(negedge clk_i);
			n++;
		end
		chk(done_o, 1'b1);
	endtask : wait_done

	task automatic check_frame(input logic [31:0] b, input logic [3:0] f, input int nw);
		logic [15:0] w [10];
		w = '{sr_i, pc_i[31:16], pc_i[15:0], {f, vec_off_i}, iaddr_i[31:16],
			iaddr_i[15:0], intregs_i[63:48], intregs_i[47:32], intregs_i[31:16],
			intregs_i[15:0]};
		for (int k = 0; k < nw / 2; k++) begin
			chk(mem.store[b[13:2] + 12'(k)], {w[2 * k], w[2 * k + 1]});
		end
	endtask : check_frame

	task automatic push(input logic [4:0] c, input logic thr, input logic [3:0] f,
		input int nw, input logic [3:0] d);
		logic [31:0] b;
		int          w0;
		dly         = d;
		exc_cause_i = c;
		throwaway_i = thr;
		vec_off_i   = {5'h00, c, 2'h0};
		sr_i        = 16'h2700 ^ {11'h000, c};
		pc_i        = 32'h0001_0000 + {27'h0, c};
		iaddr_i     = 32'h0002_0000 - {27'h0, c};
		intregs_i   = 64'h1111_2222_3333_4444 ^ {59'h0, c};
		sp_i        = 32'h0000_4000 - {21'h0, c, 6'h00};
		b           = sp_i - 32'(2 * nw);
		w0          = mem.wr_cnt;
		@(negedge clk_i);
		exc_req_i = 1'b1;
		@(negedge clk_i);
		exc_req_i = 1'b0;
		chk(busy_o, 1'b1);
		wait_done();
		chk(vec_fetch_o, 1'b1);
		chk(sp_o, thr ? b - 32'h8 : b);
		chk(fmt_o, thr ? ESF_FMT_THROW : f);
		chk(mem.wr_cnt - w0, nw / 2 + (thr ? 2 : 0));
		chk(mem.bad_align, 0);
		check_frame(b, f, nw);
		if (thr) check_frame(b - 32'h8, ESF_FMT_THROW, 4);
		@(negedge clk_i);
		chk(busy_o, 1'b0);
	endtask : push

	// ==========================================================
	// Scenarios
	task automatic t_normal();
		for (int i = ESF_EXC_INTERRUPT; i <= ESF_EXC_CP_PRE; i++)
			push(5'(i), 1'b0, ESF_FMT_NORMAL, 4, 4'(i % 3));
		$display("t_normal done");
	endtask : t_normal

	task automatic t_six();
		for (int i = ESF_EXC_BOUNDS; i <= ESF_EXC_CP_POST; i++)
			push(5'(i), 1'b0, ESF_FMT_SIX, 6, 4'(i % 4));
		$display("t_six done");
	endtask : t_six

	task automatic t_mid();
		for (int i = ESF_EXC_CP_MID; i <= ESF_EXC_INT_IN_CP; i++)
			push(5'(i), 1'b0, ESF_FMT_MID, 10, 4'h5);
		$display("t_mid done");
	endtask : t_mid

	task automatic t_throw_read();
		push(ESF_EXC_INTERRUPT, 1'b1, ESF_FMT_NORMAL, 4, 4'h2);
		sp_i = sp_o;
		dly  = 4'h3;
		@(negedge clk_i);
		rd_req_i = 1'b1;
		@(negedge clk_i);
		rd_req_i = 1'b0;
		wait_done();
		chk(rd_sr_o, sr_i);
		chk(rd_pc_o, pc_i);
		chk(rd_fmtvec_o, {ESF_FMT_THROW, vec_off_i});
		$display("t_throw_read done");
	endtask : t_throw_read

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (2) @(negedge clk_i);
		sys_rst_i = 1'b0;
		t_normal();
		t_six();
		t_mid();
		t_throw_read();
		final_report();
	end

	initial begin
		#400_000;
		bad_count++;
		final_report();
	end
endmodule : exception_stack_frame_builder_bench

`default_nettype wire
